// ==== reset_source_control.sv ====
/*
 * Reset source controller: pin reset select, supply-low reset with
 * threshold select, flash-control reset trigger, watchdog control
 * check, sticky cause flags and the reset sequencer.
 * Assumes rst_b_in is the power-on reset and software runs the
 * register port; pin and comparator inputs are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module reset_source_control
	import reset_source_pkg::*;
(
	// Clock and power-on reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	// Outside signals
	input wire logic external_reset_pin_in,
	input wire logic supply_low_in,
	input wire logic watchdog_timeout_in,
	// Results
	output logic system_reset_b_out,
	output logic pin_is_reset_out,
	output logic supply_low_active_out,
	output logic watchdog_enable_out
);

	// Input synchronisers
	logic [2:0] pin_sync;
	logic [2:0] low_sync;
	logic pin_level;
	logic low_level;

	// Configuration and flag registers
	logic [7:0] reset_pin_select_reg;
	logic [7:0] threshold_select_reg;
	logic [7:0] watchdog_control_reg;
	logic [3:0] reset_cause_flag_reg;
	logic watchdog_expiry_flag;
	logic power_saving;

	// Code checks and reset events
	logic pin_valid;
	logic threshold_valid;
	logic wdog_valid;
	logic soft_fault;
	logic supply_low_reset;
	logic flash_reset;
	logic wdog_reset;
	logic pin_reset_now;
	logic warm_only;
	logic restore_regs;

	// Sequencer
	seq_state_t state;
	seq_state_t next_state;

	// Register write decodes
	logic wr_pin;
	logic wr_flags;
	logic wr_threshold;
	logic wr_wdog;
	logic wr_mode;

	delay_if soft_link ();
	delay_if low_link ();
	delay_if seq_link ();

	// Asynchronous inputs through three stages
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_sync <= 3'h7;
			low_sync <= 3'h0;
			pin_level <= 1'b1;
			low_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], external_reset_pin_in};
			low_sync <= {low_sync[1:0], supply_low_in};
			// Level moves only once stages two and three agree
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
			if (low_sync[1] == low_sync[2])
				low_level <= low_sync[2];
		end
	end

	// Register write strobes
	assign wr_pin = reg_write_in && reg_addr_in == OFFSET_PIN_SELECT;
	assign wr_flags = reg_write_in && reg_addr_in == OFFSET_CAUSE_FLAGS;
	assign wr_threshold = reg_write_in && reg_addr_in == OFFSET_THRESHOLD;
	assign wr_wdog = reg_write_in && reg_addr_in == OFFSET_WATCHDOG_CTRL;
	assign wr_mode = reg_write_in && reg_addr_in == OFFSET_MODE;

	// Code checks
	assign pin_valid = reset_pin_select_reg == PIN_SELECT_IO ||
		reset_pin_select_reg == PIN_SELECT_RESET;
	always_comb begin
		case (threshold_select_reg)
		THRESHOLD_1V7, THRESHOLD_1V9, THRESHOLD_2V55, THRESHOLD_3V15,
		THRESHOLD_3V8, THRESHOLD_OFF: threshold_valid = 1'b1;
		default: threshold_valid = 1'b0;
		endcase
	end
	assign wdog_valid =
		watchdog_control_reg[WDOG_EN_MSB:WDOG_EN_LSB] == WDOG_EN_OFF ||
		watchdog_control_reg[WDOG_EN_MSB:WDOG_EN_LSB] == WDOG_EN_ON;
	assign soft_fault = !pin_valid || !threshold_valid || !wdog_valid;

	// Soft fault delay, counts only while running normally
	assign soft_link.start = 1'b0;
	assign soft_link.run = soft_fault && state == SEQ_RUN;
	delay_timer #(.CYCLES(COUNT_W'(SOFT_RESET_CYCLES))) soft_timer (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.link(soft_link)
	);

	// Supply-low qualification, masked in power saving and when off
	assign low_link.start = 1'b0;
	assign low_link.run = low_level && !power_saving &&
		threshold_select_reg != THRESHOLD_OFF && threshold_valid &&
		state == SEQ_RUN;
	delay_timer #(.CYCLES(COUNT_W'(SUPPLY_LOW_CYCLES))) low_timer (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.link(low_link)
	);
	assign supply_low_reset = low_link.done;

	// Reset events seen while running
	assign flash_reset = wr_flags == 1'b0 && reg_write_in &&
		reg_addr_in == OFFSET_FLASH_CTRL_ONE &&
		reg_wdata_in == FLASH_RESET_CODE;
	assign wdog_reset = watchdog_timeout_in && state == SEQ_RUN;
	assign pin_reset_now = reset_pin_select_reg == PIN_SELECT_RESET &&
		!pin_level;

	// Reset cause decode; only a lone watchdog expiry is a warm reset
	always_comb begin
		warm_only = 1'b0;
		restore_regs = 1'b0;
		if (state == SEQ_RUN && next_state != SEQ_RUN) begin
			warm_only = wdog_reset && !soft_link.done &&
				!supply_low_reset && !flash_reset &&
				!pin_reset_now;
			restore_regs = !warm_only;
		end
	end

	// Reset sequencer
	always_comb begin
		next_state = state;
		case (state)
		SEQ_RUN: begin
			// Pin reset wins over the other events
			if (pin_reset_now)
				next_state = SEQ_PIN_HELD;
			else if (soft_link.done || supply_low_reset || flash_reset ||
				wdog_reset)
				next_state = SEQ_PULSE;
		end
		SEQ_PULSE: begin
			if (seq_link.done)
				next_state = SEQ_RELEASE;
		end
		SEQ_PIN_HELD: begin
			// Stays here for as long as the pin is low
			if (pin_level || reset_pin_select_reg != PIN_SELECT_RESET)
				next_state = SEQ_RELEASE;
		end
		SEQ_RELEASE: begin
			// A low pin during release enters the hold if a warm reset kept the reset pin select
			if (pin_reset_now)
				next_state = SEQ_PIN_HELD;
			else if (seq_link.done)
				next_state = SEQ_RUN;
		end
		default: next_state = SEQ_RUN;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			state <= SEQ_RUN;
		else
			state <= next_state;
	end

	// One counter times both the pulse and the release
	assign seq_link.start = next_state != state;
	assign seq_link.run = state == SEQ_PULSE || state == SEQ_RELEASE;
	delay_timer #(.CYCLES(COUNT_W'(PIN_RELEASE_CYCLES))) seq_timer (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.link(seq_link)
	);

	// Pin select register
	// Restored when a pin hold ends and on entry to any non-warm reset pulse, so the hold follows the pin
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			reset_pin_select_reg <= PIN_SELECT_IO;
		else if (restore_regs && next_state == SEQ_PULSE)
			reset_pin_select_reg <= PIN_SELECT_IO;
		else if (state == SEQ_PIN_HELD && next_state != SEQ_PIN_HELD)
			reset_pin_select_reg <= PIN_SELECT_IO;
		else if (wr_pin && state == SEQ_RUN)
			reset_pin_select_reg <= reg_wdata_in;
	end

	// Threshold register
	// A real supply-low reset keeps the chosen threshold
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			threshold_select_reg <= THRESHOLD_1V7;
		else if (restore_regs && next_state != SEQ_RUN &&
			!(supply_low_reset && threshold_valid))
			threshold_select_reg <= THRESHOLD_1V7;
		else if (wr_threshold && state == SEQ_RUN)
			threshold_select_reg <= reg_wdata_in;
	end

	// Watchdog control register
	// Every reset but the warm one restores it
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			watchdog_control_reg <= WDOG_CTRL_POR;
		else if (restore_regs && next_state != SEQ_RUN)
			watchdog_control_reg <= WDOG_CTRL_POR;
		else if (wr_wdog && state == SEQ_RUN)
			watchdog_control_reg <= reg_wdata_in;
	end

	// Power saving mode from software
	// Any reset wakes the device
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			power_saving <= 1'b0;
		else if (state != SEQ_RUN)
			power_saving <= 1'b0;
		else if (wr_mode)
			power_saving <= reg_wdata_in[MODE_SAVING];
	end

	// Sticky cause flags, set wins over a software clear
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reset_cause_flag_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_flags && !reg_wdata_in[i])
					reset_cause_flag_reg[i] <= 1'b0;
			end
			if (soft_link.done && !pin_valid)
				reset_cause_flag_reg[FLAG_PIN_SELECT] <= 1'b1;
			if (supply_low_reset)
				reset_cause_flag_reg[FLAG_SUPPLY_LOW] <= 1'b1;
			if (soft_link.done && !threshold_valid)
				reset_cause_flag_reg[FLAG_THRESHOLD] <= 1'b1;
			if (soft_link.done && !wdog_valid)
				reset_cause_flag_reg[FLAG_WATCHDOG_CTRL] <= 1'b1;
		end
	end

	// Watchdog expiry flag
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in)
			watchdog_expiry_flag <= 1'b0;
		else if (wdog_reset && !power_saving)
			watchdog_expiry_flag <= 1'b1;
		else if (state == SEQ_RUN && next_state != SEQ_RUN)
			watchdog_expiry_flag <= watchdog_expiry_flag;
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_read_in) begin
			case (reg_addr_in)
			OFFSET_PIN_SELECT: reg_rdata_out <= reset_pin_select_reg;
			OFFSET_CAUSE_FLAGS: reg_rdata_out <=
				{4'h0, reset_cause_flag_reg};
			OFFSET_THRESHOLD: reg_rdata_out <= threshold_select_reg;
			OFFSET_WATCHDOG_CTRL: reg_rdata_out <= watchdog_control_reg;
			OFFSET_STATUS: reg_rdata_out <= {6'h00,
				state != SEQ_RUN, watchdog_expiry_flag};
			OFFSET_MODE: reg_rdata_out <= {7'h00, power_saving};
			default: reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// Registered outputs
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			system_reset_b_out <= 1'b0;
			pin_is_reset_out <= 1'b0;
			supply_low_active_out <= 1'b0;
			watchdog_enable_out <= 1'b0;
		end else begin
			// Reset is low whenever the sequencer is not running
			system_reset_b_out <= next_state == SEQ_RUN;
			pin_is_reset_out <=
				reset_pin_select_reg == PIN_SELECT_RESET;
			supply_low_active_out <= threshold_valid &&
				threshold_select_reg != THRESHOLD_OFF &&
				!power_saving;
			watchdog_enable_out <=
				watchdog_control_reg[WDOG_EN_MSB:WDOG_EN_LSB] == WDOG_EN_ON;
		end
	end

endmodule
`default_nettype wire

// ==== reset_source_pkg.sv ====
/*
 * Constants for the reset source controller: register offsets, field
 * positions, valid codes, power-on values and delay figures.
 * Assumes a 50 MHz system clock.
 */
package reset_source_pkg;

	localparam int CLOCK_HZ = 50000000;

	// Register offsets on the plain register port
	localparam logic [2:0] OFFSET_PIN_SELECT = 3'h0;
	localparam logic [2:0] OFFSET_CAUSE_FLAGS = 3'h1;
	localparam logic [2:0] OFFSET_THRESHOLD = 3'h2;
	localparam logic [2:0] OFFSET_FLASH_CTRL_ONE = 3'h3;
	localparam logic [2:0] OFFSET_WATCHDOG_CTRL = 3'h4;
	localparam logic [2:0] OFFSET_STATUS = 3'h5;
	localparam logic [2:0] OFFSET_MODE = 3'h6;

	// Pin select codes
	localparam logic [7:0] PIN_SELECT_IO = 8'h55;
	localparam logic [7:0] PIN_SELECT_RESET = 8'hAA;

	// Threshold codes
	localparam logic [7:0] THRESHOLD_1V7 = 8'h66;
	localparam logic [7:0] THRESHOLD_1V9 = 8'h55;
	localparam logic [7:0] THRESHOLD_2V55 = 8'h33;
	localparam logic [7:0] THRESHOLD_3V15 = 8'h99;
	localparam logic [7:0] THRESHOLD_3V8 = 8'hAA;
	localparam logic [7:0] THRESHOLD_OFF = 8'hF0;

	// Flash control one reset trigger
	localparam logic [7:0] FLASH_RESET_CODE = 8'h55;

	// Watchdog control enable field
	localparam int WDOG_EN_MSB = 7;
	localparam int WDOG_EN_LSB = 3;
	localparam logic [4:0] WDOG_EN_OFF = 5'h15;
	localparam logic [4:0] WDOG_EN_ON = 5'h0A;
	localparam logic [7:0] WDOG_CTRL_POR = 8'h53;

	// Cause flag bit positions
	localparam int FLAG_PIN_SELECT = 3;
	localparam int FLAG_SUPPLY_LOW = 2;
	localparam int FLAG_THRESHOLD = 1;
	localparam int FLAG_WATCHDOG_CTRL = 0;

	// Status register bit positions
	localparam int STATUS_EXPIRY = 0;
	localparam int STATUS_IN_RESET = 1;

	// Mode register bit: 1 = IDLE or SLEEP
	localparam int MODE_SAVING = 0;

	// Delay figures in nanoseconds
	localparam int SOFT_RESET_DELAY_NS = 1000;
	localparam int PIN_RELEASE_DELAY_NS = 2000;
	localparam int SUPPLY_LOW_MIN_NS = 500;
	localparam int RESET_PULSE_NS = 100;

	localparam int NS_PER_CYCLE = 1000000000 / CLOCK_HZ;
	localparam int SOFT_RESET_CYCLES =
		(SOFT_RESET_DELAY_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
	localparam int PIN_RELEASE_CYCLES =
		(PIN_RELEASE_DELAY_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
	localparam int SUPPLY_LOW_CYCLES =
		(SUPPLY_LOW_MIN_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
	localparam int RESET_PULSE_CYCLES =
		(RESET_PULSE_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;

	localparam int COUNT_W = 8;

	typedef enum logic [1:0] {
		SEQ_RUN = 2'b00,
		SEQ_PULSE = 2'b01,
		SEQ_PIN_HELD = 2'b10,
		SEQ_RELEASE = 2'b11
	} seq_state_t;

endpackage

// ==== delay_if.sv ====
/*
 * Request, done pair between the controller and a delay counter.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface delay_if;
	logic start;
	logic run;
	logic done;
	modport ctrl (output start, output run, input done);
	modport timer (input start, input run, output done);
endinterface
`default_nettype wire

// ==== delay_timer.sv ====
/*
 * Counts a fixed number of cycles while run is held; done pulses once
 * when the count is reached. Start restarts the count.
 * Assumes run and start come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module delay_timer
	import reset_source_pkg::*;
#(
	parameter logic [COUNT_W-1:0] CYCLES = 8'd1
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Control
	delay_if.timer link
);

	logic [COUNT_W-1:0] count;
	logic done;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= '0;
			done <= 1'b0;
		end else if (link.start || !link.run) begin
			count <= '0;
			done <= 1'b0;
		end else if (count == CYCLES - 8'd1) begin
			count <= count + 8'd1;
			done <= 1'b1;
		end else begin
			if (count != CYCLES)
				count <= count + 8'd1;
			done <= 1'b0;
		end
	end

	assign link.done = done;

endmodule
`default_nettype wire

// ==== reset_source_checker.sv ====
/*
 * Port checker for the reset source controller.
 * Assumes one clock and the active-low power-on reset of the top.
 */
`timescale 1ns/10ps
`default_nettype none
module reset_source_checker
	import reset_source_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic external_reset_pin_in,
	input wire logic supply_low_in,
	input wire logic watchdog_timeout_in,
	input wire logic system_reset_b_out,
	input wire logic pin_is_reset_out,
	input wire logic supply_low_active_out,
	input wire logic watchdog_enable_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);
	logic pin_bad;
	logic thr_bad;
	logic [7:0] low_run;
	assign pin_bad = reg_write_in && reg_addr_in == OFFSET_PIN_SELECT &&
		!(reg_wdata_in inside {PIN_SELECT_IO, PIN_SELECT_RESET});
	assign thr_bad = reg_write_in && reg_addr_in == OFFSET_THRESHOLD &&
		!(reg_wdata_in inside {THRESHOLD_1V7, THRESHOLD_1V9, THRESHOLD_2V55,
		THRESHOLD_3V15, THRESHOLD_3V8, THRESHOLD_OFF});
	// Length of the current supply-low indication
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_run <= 8'h00;
		end else begin
			low_run <= supply_low_in ? low_run + 8'h01 : 8'h00;
		end
	end
	flag_upper_zero_a:
		assert property (reg_read_in && reg_addr_in == OFFSET_CAUSE_FLAGS
		|=> reg_rdata_out[7:4] == 4'h0) else $error("flag upper bits set");
	pin_soft_delay_a:
		assert property (pin_bad && system_reset_b_out |=> system_reset_b_out[*8]
		##[1:60] !system_reset_b_out) else $error("pin select reset timing");
	thr_soft_delay_a:
		assert property (thr_bad && system_reset_b_out |=> system_reset_b_out[*8]
		##[1:60] !system_reset_b_out) else $error("threshold reset timing");
	flash_reset_a:
		assert property (reg_write_in && reg_addr_in == OFFSET_FLASH_CTRL_ONE &&
		reg_wdata_in == FLASH_RESET_CODE && system_reset_b_out
		|-> ##[1:8] !system_reset_b_out) else $error("flash reset missing");
	pin_low_reset_a:
		assert property ($fell(external_reset_pin_in) && pin_is_reset_out
		|-> ##[1:8] !system_reset_b_out) else $error("pin reset missing");
	release_hold_a:
		assert property ($rose(external_reset_pin_in) && !system_reset_b_out
		|=> !system_reset_b_out[*8]) else $error("pin release too early");
	short_low_ignored_a:
		assert property ($fell(supply_low_in) && $past(low_run) < 8'd20 &&
		system_reset_b_out |-> system_reset_b_out[*8])
		else $error("short supply low caused reset");
	warm_keep_select_a:
		assert property (watchdog_timeout_in && pin_is_reset_out &&
		system_reset_b_out |=> pin_is_reset_out[*8])
		else $error("warm reset lost pin select");
	saving_no_detect_a:
		assert property (reg_write_in && reg_addr_in == OFFSET_MODE &&
		reg_wdata_in[MODE_SAVING] && system_reset_b_out
		|-> ##[1:3] !supply_low_active_out) else $error("detect on in saving");
	cover property (pin_bad && system_reset_b_out);
	cover property ($fell(external_reset_pin_in) && pin_is_reset_out);
	cover property (watchdog_timeout_in && pin_is_reset_out);
endmodule
bind reset_source_control reset_source_checker u_reset_source_checker (
	.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
	.external_reset_pin_in(external_reset_pin_in),
	.supply_low_in(supply_low_in), .watchdog_timeout_in(watchdog_timeout_in),
	.system_reset_b_out(system_reset_b_out),
	.pin_is_reset_out(pin_is_reset_out),
	.supply_low_active_out(supply_low_active_out),
	.watchdog_enable_out(watchdog_enable_out));
`default_nettype wire

// ==== reset_source_control_test.sv ====
/*
 * Self-checking bench for the reset source controller.
 * Assumes the package, interface, timer and checker compile first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module reset_source_control_test;
	import reset_source_pkg::*;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wd = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic pin = 1'b1;
	logic low = 1'b0;
	logic wdt = 1'b0;
	logic [7:0] rdata;
	logic srst;
	logic pin_rst;
	logic sl_act;
	logic wd_en;
	int bad_count = 0;
	int num_checks = 0;
	logic [7:0] codes [6] = '{THRESHOLD_1V7, THRESHOLD_1V9, THRESHOLD_2V55,
		THRESHOLD_3V15, THRESHOLD_3V8, THRESHOLD_OFF};
	always #10 clock_in = ~clock_in;
	reset_source_control u_reset_source_control (
		.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .external_reset_pin_in(pin),
		.supply_low_in(low), .watchdog_timeout_in(wdt),
		.system_reset_b_out(srst), .pin_is_reset_out(pin_rst),
		.supply_low_active_out(sl_act), .watchdog_enable_out(wd_en));
	task automatic close_out;
		if (bad_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clock_in);
		addr <= ad;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clock_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge clock_in);
		addr <= ad;
		rd_s <= 1'b1;
		@(posedge clock_in);
		rd_s <= 1'b0;
		#1;
		`CHK("read", e, rdata)
	endtask
	// Reset must fall after at least pre cycles and stay low hold cycles
	task automatic cyc(input int pre, input int hold);
		int n;
		int m;
		n = 0;
		m = 0;
		while (srst === 1'b1 && n < 400) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		low <= 1'b0;
		while (srst !== 1'b1 && m < 600) begin
			@(posedge clock_in);
			#1;
			m++;
		end
		`CHK("delay", 1'b1, n >= pre && n < 400)
		`CHK("hold", 1'b1, m >= hold && m < 600)
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clock_in);
			#1;
			`CHK("running", 1'b1, srst)
		end
	endtask
	initial begin
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rd(OFFSET_PIN_SELECT, PIN_SELECT_IO);
		rd(OFFSET_THRESHOLD, THRESHOLD_1V7);
		rd(OFFSET_CAUSE_FLAGS, 8'h00);
		rd(3'h7, 8'h00);
		`CHK("detect", 1'b1, sl_act)
		`CHK("wdog", 1'b1, wd_en)
		foreach (codes[i]) begin
			wr(OFFSET_THRESHOLD, codes[i]);
			rd(OFFSET_THRESHOLD, codes[i]);
		end
		quiet(60);
		`CHK("detect", 1'b0, sl_act)
		wr(OFFSET_THRESHOLD, 8'h12);
		cyc(SOFT_RESET_CYCLES - 3, PIN_RELEASE_CYCLES);
		rd(OFFSET_THRESHOLD, THRESHOLD_1V7);
		rd(OFFSET_CAUSE_FLAGS, 8'h02);
		wr(OFFSET_CAUSE_FLAGS, 8'h00);
		rd(OFFSET_CAUSE_FLAGS, 8'h00);
		wr(OFFSET_PIN_SELECT, 8'h12);
		cyc(SOFT_RESET_CYCLES - 3, PIN_RELEASE_CYCLES);
		rd(OFFSET_PIN_SELECT, PIN_SELECT_IO);
		rd(OFFSET_CAUSE_FLAGS, 8'h08);
		wr(OFFSET_CAUSE_FLAGS, 8'hFF);
		rd(OFFSET_CAUSE_FLAGS, 8'h08);
		wr(OFFSET_CAUSE_FLAGS, 8'h00);
		rd(OFFSET_CAUSE_FLAGS, 8'h00);
		wr(OFFSET_PIN_SELECT, PIN_SELECT_RESET);
		rd(OFFSET_PIN_SELECT, PIN_SELECT_RESET);
		`CHK("pin mode", 1'b1, pin_rst)
		pin <= 1'b0;
		repeat (150) @(posedge clock_in);
		#1;
		`CHK("pin held", 1'b0, srst)
		rd(OFFSET_STATUS, 8'h02);
		@(posedge clock_in);
		pin <= 1'b1;
		cyc(0, PIN_RELEASE_CYCLES);
		rd(OFFSET_PIN_SELECT, PIN_SELECT_IO);
		wr(OFFSET_PIN_SELECT, PIN_SELECT_RESET);
		@(posedge clock_in);
		wdt <= 1'b1;
		@(posedge clock_in);
		wdt <= 1'b0;
		cyc(0, 1);
		rd(OFFSET_PIN_SELECT, PIN_SELECT_RESET);
		rd(OFFSET_STATUS, 8'h01);
		wr(OFFSET_PIN_SELECT, PIN_SELECT_IO);
		wr(OFFSET_THRESHOLD, THRESHOLD_2V55);
		@(posedge clock_in);
		low <= 1'b1;
		repeat (SUPPLY_LOW_CYCLES - 10) @(posedge clock_in);
		low <= 1'b0;
		quiet(40);
		wr(OFFSET_MODE, 8'h01);
		low <= 1'b1;
		quiet(60);
		`CHK("detect", 1'b0, sl_act)
		wr(OFFSET_MODE, 8'h00);
		cyc(SUPPLY_LOW_CYCLES - 3, PIN_RELEASE_CYCLES);
		rd(OFFSET_THRESHOLD, THRESHOLD_2V55);
		rd(OFFSET_CAUSE_FLAGS, 8'h04);
		wr(OFFSET_CAUSE_FLAGS, 8'h00);
		wr(OFFSET_FLASH_CTRL_ONE, FLASH_RESET_CODE);
		cyc(0, PIN_RELEASE_CYCLES);
		rd(OFFSET_FLASH_CTRL_ONE, 8'h00);
		wr(OFFSET_WATCHDOG_CTRL, 8'hAB);
		quiet(3);
		`CHK("wdog", 1'b0, wd_en)
		wr(OFFSET_WATCHDOG_CTRL, 8'h00);
		cyc(SOFT_RESET_CYCLES - 3, PIN_RELEASE_CYCLES);
		rd(OFFSET_CAUSE_FLAGS, 8'h01);
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		bad_count++;
		close_out;
	end
endmodule
`default_nettype wire
